/* File: verilog/ccrs_core.sv */
// Notes on behaviour
// - decode memory types 1 to 9 as the nine named target memories
// - types 13-16 set, 17-20 clear, 21-22 toggle a bit; 12 unused
// - types 13 to 22 valid only with enhanced firmware
// - types 4-7 and matching absolute regions writable only with protect switch on write
// - absolute type 0 regions: scratch 4096-4351, registers 16384-32767, user logic above
// - input and output start point must be 1 plus a multiple of eight
// - fast shared buffer start byte 0 through 1023
// - diagnostic word start 1 through 20
// - types 10 and 11 only with panel timer command, total at most 512
// - length units follow source type; buffer 1-1024 bytes, diagnostics 1-20 words
// - point lengths multiple of 8 within 8-1024; start point beyond 1024 needs enhanced firmware and a length multiple of 16
// - status byte sent to the CPU every exchange window
// - busy bit set on accepted request, cleared on completion; CPU waits on it
// - pulse bits 1-5 for done, error, external read, external write, quick response
// - each pulse high three windows, then low three windows
// - bits 1, 2, 5 queue pulses in a wrapping 8-bit counter
// - bits 3 and 4 drop events arriving while their pulse runs
// - link-ok bit set after self test and each healthy window; CPU may clear
// - twenty diagnostic words kept inside, copied out only on read command
// - external read of memory type 9 reaches the diagnostic words
// - memory type 0 means absolute addressing
`default_nettype none
module ccrs_core
    import ccrs_pkg::*;
#(
    parameter int DIAG_COUNT = 20
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire logic [15:0] req_command,
    input wire logic [4:0] req_mem_type,
    input wire logic [15:0] req_address,
    input wire logic [15:0] req_length,
    input wire logic req_write,
    input wire logic enhanced_fw,
    input wire logic protect_write_pin,
    output logic req_accept,
    output logic [3:0] check_code,
    output logic xfer_start,
    input wire logic xfer_done,
    input wire logic xfer_error,
    input wire logic comm_active,
    input wire logic ext_read_ok,
    input wire logic ext_write_ok,
    input wire logic quick_resp_sent,
    input wire logic window,
    input wire logic self_test_pass,
    input wire logic cpu_comm_ok,
    input wire logic link_ok_clear,
    output logic [7:0] status_byte,
    input wire logic diag_wr_en,
    input wire logic [4:0] diag_wr_index,
    input wire logic [15:0] diag_wr_data,
    input wire logic diag_clear,
    input wire logic diag_rd_en,
    input wire logic [4:0] diag_rd_index,
    output logic diag_rd_valid,
    output logic [15:0] diag_rd_data
);
    // ------------------------------------------------------------
    // request checking
    // ------------------------------------------------------------
    function automatic logic point_ok(input logic [15:0] addr, input logic [15:0] len,
                                      input logic enh);
        logic base_ok;
        base_ok = (addr != 16'h0000) && (addr[2:0] == 3'h1);
        if (addr <= POINT_BASE_LIMIT) begin
            point_ok = base_ok && (len[2:0] == 3'h0) && (len >= POINT_LEN_MIN)
                && (len <= POINT_LEN_MAX);
        end else begin
            point_ok = base_ok && enh && (len[3:0] == 4'h0) && (len != 16'h0000)
                && (len <= POINT_EXT_LEN_MAX);
        end
    endfunction

    function automatic logic [3:0] check_request(input logic [4:0] mt, input logic [15:0] addr,
                                                 input logic [15:0] len, input logic wr,
                                                 input logic enh, input logic prot_ok,
                                                 input logic [15:0] cmd);
        logic prot;
        check_request = CHK_OK;
        prot = 1'b0;
        unique case (1'b1)
            mt == MT_ABSOLUTE: begin
                if (addr >= ABS_USER_LO) begin
                    prot = 1'b1;
                end else if (addr >= ABS_REGISTER_LO) begin
                    prot = 1'b0;
                end else if (addr >= ABS_SCRATCH_LO && addr <= ABS_SCRATCH_HI) begin
                    prot = 1'b1;
                end else begin
                    check_request = CHK_ADDR_LEN;
                end
                if (len == 16'h0000) begin
                    check_request = CHK_ADDR_LEN;
                end
            end
            mt == MT_REGISTER: begin
                if (addr == 16'h0000 || len == 16'h0000) begin
                    check_request = CHK_ADDR_LEN;
                end
            end
            mt == MT_INPUT || mt == MT_OUTPUT: begin
                if (!point_ok(addr, len, enh)) begin
                    check_request = CHK_ADDR_LEN;
                end
            end
            mt == MT_IN_OVR || mt == MT_OUT_OVR: begin
                prot = 1'b1;
                if (!point_ok(addr, len, enh)) begin
                    check_request = CHK_ADDR_LEN;
                end
            end
            mt == MT_SCRATCH: begin
                prot = 1'b1;
                if (addr > SCRATCH_ADDR_MAX || len == 16'h0000) begin
                    check_request = CHK_ADDR_LEN;
                end
            end
            mt == MT_USER_LOGIC: begin
                prot = 1'b1;
                if (len == 16'h0000) begin
                    check_request = CHK_ADDR_LEN;
                end
            end
            mt == MT_FAST_BUF: begin
                if (addr > FAST_BUF_ADDR_MAX || len == 16'h0000 || len > FAST_BUF_LEN_MAX) begin
                    check_request = CHK_DIAG_BUF;
                end
            end
            mt == MT_DIAG: begin
                if (addr == 16'h0000 || addr > DIAG_WORDS || len == 16'h0000
                    || len > DIAG_WORDS) begin
                    check_request = CHK_DIAG_BUF;
                end
            end
            mt == MT_TIMERS || mt == MT_COUNTERS: begin
                if (cmd != CMD_PANEL_TIMERS) begin
                    check_request = CHK_MEM_TYPE;
                end else if (addr > TIMER_TOTAL_MAX) begin
                    check_request = CHK_ADDR_LEN;
                end
            end
            mt >= MT_BIT_SET_FIRST && mt <= MT_LAST: begin
                // bit operations are single point writes, so no length check
                prot = (mt - MT_BIT_SET_FIRST) % 5'h4 >= 5'h2 && mt < MT_BIT_TGL_FIRST;
                if (!enh || addr == 16'h0000) begin
                    check_request = enh ? CHK_ADDR_LEN : CHK_MEM_TYPE;
                end
            end
            default: begin
                check_request = CHK_MEM_TYPE;
            end
        endcase
        if (check_request == CHK_OK && prot && (wr || mt >= MT_BIT_SET_FIRST) && !prot_ok) begin
            check_request = CHK_PROTECT;
        end
    endfunction

    // ------------------------------------------------------------
    // protect switch synchroniser
    // ------------------------------------------------------------
    logic protect_meta;
    logic protect_sync;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            protect_meta <= 1'b0;
            protect_sync <= 1'b0;
        end else begin
            protect_meta <= protect_write_pin;
            protect_sync <= protect_meta;
        end
    end

    // ------------------------------------------------------------
    // request sequencer
    // ------------------------------------------------------------
    ccrs_state_type state;
    logic [3:0] next_code;
    logic busy;
    logic done_event;
    logic error_event;

    assign next_code = check_request(req_mem_type, req_address, req_length, req_write,
                                     enhanced_fw, protect_sync, req_command);
    // a new request is only taken while idle; the CPU is expected to wait on busy
    assign req_accept = req_valid && (state == CCRS_IDLE);
    assign busy = (state != CCRS_IDLE);
    assign done_event = (state == CCRS_BUSY) && xfer_done && !xfer_error;
    assign error_event = (state == CCRS_REJECT) || ((state == CCRS_BUSY) && xfer_error);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state <= CCRS_IDLE;
            check_code <= CHK_OK;
            xfer_start <= 1'b0;
        end else begin
            xfer_start <= 1'b0;
            unique case (state)
                CCRS_IDLE: begin
                    if (req_accept) begin
                        check_code <= next_code;
                        if (next_code == CHK_OK) begin
                            state <= CCRS_BUSY;
                            xfer_start <= 1'b1;
                        end else begin
                            state <= CCRS_REJECT;
                        end
                    end
                end
                CCRS_BUSY: begin
                    if (xfer_done || xfer_error) begin
                        state <= CCRS_IDLE;
                    end
                end
                CCRS_REJECT: begin
                    state <= CCRS_IDLE;
                end
                default: begin
                    state <= CCRS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // status pulses
    // ------------------------------------------------------------
    logic [PULSE_BITS-1:0] pulse_event;
    logic [PULSE_BITS-1:0] pulse_queued;
    logic [PULSE_BITS-1:0] pulse_level;
    ccrs_pulse_type pulse_phase [PULSE_BITS];
    logic [1:0] pulse_windows [PULSE_BITS];
    logic [7:0] pulse_pending [PULSE_BITS];

    assign pulse_event = {quick_resp_sent, ext_write_ok, ext_read_ok, error_event,
                          done_event};
    assign pulse_queued = 5'h13;

    for (genvar i = 0; i < PULSE_BITS; i++) begin : g_pulse
        logic idle;
        logic start;
        assign idle = (pulse_phase[i] == CCRS_P_OFF);
        // queued bits drain only once the link has gone quiet
        assign start = idle && (pulse_queued[i]
            ? ((pulse_pending[i] != 8'h00) && !comm_active) : pulse_event[i]);
        assign pulse_level[i] = (pulse_phase[i] == CCRS_P_HIGH);

        always_ff @(posedge clock) begin
            if (!rst_b) begin
                pulse_pending[i] <= 8'h00;
            end else if (pulse_queued[i]) begin
                // counter rolls over past 255 by plain wrap of the 8-bit sum
                pulse_pending[i] <= pulse_pending[i] + {7'h00, pulse_event[i]}
                    - {7'h00, start};
            end
        end

        always_ff @(posedge clock) begin
            if (!rst_b) begin
                pulse_phase[i] <= CCRS_P_OFF;
                pulse_windows[i] <= 2'h0;
            end else begin
                unique case (pulse_phase[i])
                    CCRS_P_OFF: begin
                        if (start) begin
                            // events on bits 3 and 4 during a pulse never reach here and are lost
                            pulse_phase[i] <= CCRS_P_HIGH;
                            pulse_windows[i] <= 2'h0;
                        end
                    end
                    CCRS_P_HIGH: begin
                        if (window) begin
                            if (pulse_windows[i] == PULSE_WINDOWS - 2'h1) begin
                                pulse_phase[i] <= CCRS_P_LOW;
                                pulse_windows[i] <= 2'h0;
                            end else begin
                                pulse_windows[i] <= pulse_windows[i] + 2'h1;
                            end
                        end
                    end
                    CCRS_P_LOW: begin
                        if (window) begin
                            if (pulse_windows[i] == PULSE_WINDOWS - 2'h1) begin
                                pulse_phase[i] <= CCRS_P_OFF;
                                pulse_windows[i] <= 2'h0;
                            end else begin
                                pulse_windows[i] <= pulse_windows[i] + 2'h1;
                            end
                        end
                    end
                    default: begin
                        pulse_phase[i] <= CCRS_P_OFF;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // link health and status byte
    // ------------------------------------------------------------
    logic link_ok;
    logic self_test_seen;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            self_test_seen <= 1'b0;
        end else if (self_test_pass) begin
            self_test_seen <= 1'b1;
        end
    end

    // set wins over the CPU clear; a failing link simply stops setting it
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            link_ok <= 1'b0;
        end else if (self_test_pass || (window && self_test_seen && cpu_comm_ok)) begin
            link_ok <= 1'b1;
        end else if (link_ok_clear) begin
            link_ok <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            status_byte <= STATUS_RESET;
        end else if (window) begin
            status_byte[ST_BUSY] <= busy;
            status_byte[ST_PULSE_LO +: PULSE_BITS] <= pulse_level;
            status_byte[ST_SPARE] <= 1'b0;
            status_byte[ST_LINK_OK] <= link_ok || (self_test_seen && cpu_comm_ok);
        end
    end

    // ------------------------------------------------------------
    // diagnostic words
    // ------------------------------------------------------------
    logic [15:0] diag_mem [DIAG_COUNT];

    always_ff @(posedge clock) begin
        if (!rst_b || diag_clear) begin
            for (int k = 0; k < DIAG_COUNT; k++) begin
                diag_mem[k] <= 16'h0000;
            end
        end else if (diag_wr_en && diag_wr_index < 5'(DIAG_COUNT)) begin
            diag_mem[diag_wr_index] <= diag_wr_data;
        end
    end

    // words leave only on an explicit read, internal or from a type 9 request
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            diag_rd_valid <= 1'b0;
            diag_rd_data <= 16'h0000;
        end else begin
            diag_rd_valid <= diag_rd_en;
            if (diag_rd_en) begin
                diag_rd_data <= (diag_rd_index < 5'(DIAG_COUNT))
                    ? diag_mem[diag_rd_index] : 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verilog/ccrs_pkg.sv */
`default_nettype none
package ccrs_pkg;
    // ------------------------------------------------------------
    // memory type codes
    // ------------------------------------------------------------
    localparam logic [4:0] MT_ABSOLUTE = 5'h00;
    localparam logic [4:0] MT_REGISTER = 5'h01;
    localparam logic [4:0] MT_INPUT = 5'h02;
    localparam logic [4:0] MT_OUTPUT = 5'h03;
    localparam logic [4:0] MT_IN_OVR = 5'h04;
    localparam logic [4:0] MT_OUT_OVR = 5'h05;
    localparam logic [4:0] MT_SCRATCH = 5'h06;
    localparam logic [4:0] MT_USER_LOGIC = 5'h07;
    localparam logic [4:0] MT_FAST_BUF = 5'h08;
    localparam logic [4:0] MT_DIAG = 5'h09;
    localparam logic [4:0] MT_TIMERS = 5'h0A;
    localparam logic [4:0] MT_COUNTERS = 5'h0B;
    localparam logic [4:0] MT_UNUSED = 5'h0C;
    localparam logic [4:0] MT_BIT_SET_FIRST = 5'h0D;
    localparam logic [4:0] MT_BIT_CLR_FIRST = 5'h11;
    localparam logic [4:0] MT_BIT_TGL_FIRST = 5'h15;
    localparam logic [4:0] MT_LAST = 5'h16;
    // ------------------------------------------------------------
    // absolute address regions
    // ------------------------------------------------------------
    localparam logic [15:0] ABS_SCRATCH_LO = 16'h1000;
    localparam logic [15:0] ABS_SCRATCH_HI = 16'h10FF;
    localparam logic [15:0] ABS_REGISTER_LO = 16'h4000;
    localparam logic [15:0] ABS_USER_LO = 16'h8000;
    // ------------------------------------------------------------
    // ranges and limits
    // ------------------------------------------------------------
    localparam logic [15:0] POINT_BASE_LIMIT = 16'h0400;
    localparam logic [15:0] POINT_LEN_MIN = 16'h0008;
    localparam logic [15:0] POINT_LEN_MAX = 16'h0400;
    localparam logic [15:0] POINT_EXT_LEN_MAX = 16'h8000;
    localparam logic [15:0] SCRATCH_ADDR_MAX = 16'h00FF;
    localparam logic [15:0] FAST_BUF_ADDR_MAX = 16'h03FF;
    localparam logic [15:0] FAST_BUF_LEN_MAX = 16'h0400;
    localparam logic [15:0] DIAG_WORDS = 16'h0014;
    localparam logic [15:0] TIMER_TOTAL_MAX = 16'h0200;
    localparam logic [15:0] CMD_PANEL_TIMERS = 16'h177C;
    // ------------------------------------------------------------
    // check result codes
    // ------------------------------------------------------------
    localparam logic [3:0] CHK_OK = 4'h0;
    localparam logic [3:0] CHK_ADDR_LEN = 4'h2;
    localparam logic [3:0] CHK_DIAG_BUF = 4'h3;
    localparam logic [3:0] CHK_PROTECT = 4'h4;
    localparam logic [3:0] CHK_MEM_TYPE = 4'hA;
    // ------------------------------------------------------------
    // status byte layout and pulse timing
    // ------------------------------------------------------------
    localparam int ST_BUSY = 0;
    localparam int ST_PULSE_LO = 1;
    localparam int ST_SPARE = 6;
    localparam int ST_LINK_OK = 7;
    localparam int PULSE_BITS = 5;
    localparam logic [1:0] PULSE_WINDOWS = 2'h3;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    typedef enum logic [1:0] {
        CCRS_IDLE = 2'b00,
        CCRS_BUSY = 2'b01,
        CCRS_REJECT = 2'b10
    } ccrs_state_type;
    typedef enum logic [1:0] {
        CCRS_P_OFF = 2'b00,
        CCRS_P_HIGH = 2'b01,
        CCRS_P_LOW = 2'b10
    } ccrs_pulse_type;
endpackage
`default_nettype wire

/* File: test/ccrs_core_sva.sv */
`default_nettype none
module ccrs_core_sva
    import ccrs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire logic [4:0] req_mem_type,
    input wire logic [15:0] req_address,
    input wire logic enhanced_fw,
    input wire logic req_accept,
    input wire logic [3:0] check_code,
    input wire logic xfer_start,
    input wire logic window,
    input wire logic [7:0] status_byte,
    input wire logic diag_rd_en,
    input wire logic [4:0] diag_rd_index,
    input wire logic diag_rd_valid,
    input wire logic [15:0] diag_rd_data
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----
    // request, status and diagnostic read checks
    // ----
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_accept_needs_req: assert property (req_accept |-> req_valid)
        else $error("accept without request");
    a_busy_blocks: assert property (xfer_start |-> !req_accept && $past(req_accept))
        else $error("accept while busy");
    a_unused_type: assert property (req_accept && req_mem_type == MT_UNUSED
        |=> !xfer_start && check_code == CHK_MEM_TYPE) else $error("type 12 taken");
    a_enh_gate: assert property (req_accept && !enhanced_fw &&
        req_mem_type >= MT_BIT_SET_FIRST && req_mem_type <= MT_LAST
        |=> check_code == CHK_MEM_TYPE) else $error("bit op without enhanced");
    a_fast_buf_addr: assert property (req_accept && req_mem_type == MT_FAST_BUF &&
        req_address > FAST_BUF_ADDR_MAX |=> !xfer_start) else $error("buffer address");
    a_diag_word_addr: assert property (req_accept && req_mem_type == MT_DIAG &&
        (req_address == 16'h0000 || req_address > 16'h0014) |=> !xfer_start)
        else $error("diag word address");
    a_byte_per_window: assert property ($past(rst_b) && !$past(window)
        |-> $stable(status_byte)) else $error("status moved off window");
    a_spare_low: assert property (status_byte[ST_SPARE] == 1'h0)
        else $error("spare bit set");
    a_diag_out_range: assert property (diag_rd_en && diag_rd_index >= 5'h14
        |=> diag_rd_valid && diag_rd_data == 16'h0000) else $error("diag index");
endmodule
bind ccrs_core ccrs_core_sva chk (.*);
`default_nettype wire

/* File: test/ccrs_cpu_model.sv */
`default_nettype none
module ccrs_cpu_model #(
    parameter int WIN = 8,
    parameter int DLY = 12
) (
    input wire logic clock,
    input wire logic xfer_start,
    input wire logic fail,
    output logic window,
    output logic xfer_done,
    output logic xfer_error
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----
    // cpu side: windows and transfer answers
    // ----
    int wcnt = 0;
    int dcnt = 0;
    initial window = 1'h0;
    initial xfer_done = 1'h0;
    initial xfer_error = 1'h0;
    always @(negedge clock) begin
        window <= (wcnt == WIN - 1);
        wcnt <= (wcnt == WIN - 1) ? 0 : wcnt + 1;
        // one answer per started transfer, never early
        xfer_done <= (dcnt == 1) && !fail;
        xfer_error <= (dcnt == 1) && fail;
        if (xfer_start) begin
            dcnt <= DLY;
        end else if (dcnt != 0) begin
            dcnt <= dcnt - 1;
        end
    end
endmodule
`default_nettype wire

/* File: test/ccrs_core_tb.sv */
`default_nettype none
module ccrs_core_tb;
    import ccrs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [4:0] t; logic [15:0] a; logic [15:0] l; logic w; logic [15:0] c;
        logic e; logic p; logic [3:0] x;} ccrs_case_type;
    logic clock = 1'h0, rst_b = 1'h0, req_valid = 1'h0, req_write = 1'h0, enhanced_fw = 1'h0;
    logic protect_write_pin = 1'h0, comm_active = 1'h0, ext_read_ok = 1'h0, fail = 1'h0;
    logic ext_write_ok = 1'h0, quick_resp_sent = 1'h0, self_test_pass = 1'h0, cpu_comm_ok = 1'h0;
    logic link_ok_clear = 1'h0, diag_wr_en = 1'h0, diag_clear = 1'h0, diag_rd_en = 1'h0;
    logic [15:0] req_command = 16'h0000, req_address = 16'h0000, req_length = 16'h0000;
    logic [15:0] diag_wr_data = 16'h0000;
    logic [4:0] req_mem_type = 5'h00, diag_wr_index = 5'h00, diag_rd_index = 5'h00;
    logic req_accept, xfer_start, xfer_done, xfer_error, window, diag_rd_valid;
    logic [3:0] check_code;
    logic [7:0] status_byte;
    logic [15:0] diag_rd_data;
    int n_errors = 0;
    int checks_done = 0;
    int hits[8];
    // ----
    // mix of refused and accepted requests
    // ----
    ccrs_case_type cases[23] = '{
        '{MT_UNUSED, 16'h0001, 16'h0001, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_MEM_TYPE},
        '{5'h0D, 16'h0001, 16'h0001, 1'h1, 16'h17D5, 1'h0, 1'h0, CHK_MEM_TYPE},
        '{MT_TIMERS, 16'h000A, 16'h0001, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_MEM_TYPE},
        '{MT_SCRATCH, 16'h0000, 16'h0001, 1'h1, 16'h17D5, 1'h0, 1'h0, CHK_PROTECT},
        '{MT_ABSOLUTE, 16'h1000, 16'h0001, 1'h1, 16'h17D5, 1'h0, 1'h0, CHK_PROTECT},
        '{MT_ABSOLUTE, 16'h2000, 16'h0001, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_ADDR_LEN},
        '{MT_INPUT, 16'h000A, 16'h0010, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_ADDR_LEN},
        '{MT_OUTPUT, 16'h0009, 16'h000C, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_ADDR_LEN},
        '{MT_INPUT, 16'h0009, 16'h0408, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_ADDR_LEN},
        '{MT_FAST_BUF, 16'h0400, 16'h0001, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_DIAG_BUF},
        '{MT_FAST_BUF, 16'h0000, 16'h0401, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_DIAG_BUF},
        '{MT_DIAG, 16'h0015, 16'h0001, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_DIAG_BUF},
        '{MT_DIAG, 16'h0001, 16'h0015, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_DIAG_BUF},
        '{MT_INPUT, 16'h0009, 16'h0010, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_OK},
        '{MT_FAST_BUF, 16'h03FF, 16'h0400, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_OK},
        '{MT_DIAG, 16'h0014, 16'h0001, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_OK},
        '{MT_TIMERS, 16'h0200, 16'h0001, 1'h0, 16'h177C, 1'h0, 1'h0, CHK_OK},
        '{MT_ABSOLUTE, 16'h4000, 16'h0001, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_OK},
        '{MT_REGISTER, 16'h0001, 16'h0001, 1'h0, 16'h17D5, 1'h0, 1'h0, CHK_OK},
        '{5'h0D, 16'h0001, 16'h0001, 1'h1, 16'h17D5, 1'h1, 1'h1, CHK_OK},
        '{MT_LAST, 16'h0001, 16'h0001, 1'h1, 16'h17D5, 1'h1, 1'h1, CHK_OK},
        '{MT_SCRATCH, 16'h0000, 16'h0001, 1'h1, 16'h17D5, 1'h0, 1'h1, CHK_OK},
        '{MT_TIMERS, 16'h0201, 16'h0001, 1'h0, 16'h177C, 1'h0, 1'h0, CHK_ADDR_LEN}};
    ccrs_core uut (.*);
    ccrs_cpu_model cpu (.*);
    always #12.5 clock = ~clock;
    // windows counted in the background so no pulse is missed between calls
    always @(negedge clock iff window === 1'h1) begin
        foreach (hits[k]) hits[k] += (status_byte[k] === 1'h1);
    end
    task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic win(int n);
        repeat (n) @(negedge clock iff window === 1'h1);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        @(negedge clock);
        s = 1'h0;
        @(negedge clock);
    endtask
    task automatic run(ccrs_case_type k);
        {enhanced_fw, protect_write_pin, req_write} = {k.e, k.p, k.w};
        {req_mem_type, req_address, req_length, req_command} = {k.t, k.a, k.l, k.c};
        repeat (3) @(negedge clock);
        req_valid = 1'h1;
        #1 cmp("accept", 16'h0001, req_accept);
        @(negedge clock);
        req_valid = 1'h0;
        cmp("check code", k.x, check_code);
        cmp("start", k.x == CHK_OK, xfer_start);
        if (k.x == CHK_OK) begin
            @(negedge clock);
            req_valid = 1'h1;
            #1 cmp("accept when busy", 16'h0000, req_accept);
            @(negedge clock);
            req_valid = 1'h0;
            win(1);
            cmp("busy bit", 16'h0001, status_byte[ST_BUSY]);
        end
        repeat (10) @(negedge clock);
        win(1);
        cmp("busy bit", 16'h0000, status_byte[ST_BUSY]);
    endtask
    task automatic diag(logic wr, logic [4:0] i, logic [15:0] d);
        {diag_wr_en, diag_wr_index, diag_wr_data} = {wr, i, d};
        {diag_rd_en, diag_rd_index} = {!wr, i};
        @(negedge clock);
        {diag_wr_en, diag_rd_en} = 2'h0;
        if (!wr) cmp("diag valid", 16'h0001, diag_rd_valid);
        if (!wr) cmp("diag data", d, diag_rd_data);
        @(negedge clock);
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (16) @(negedge clock);
        rst_b = 1'h1;
        cmp("status after reset", 16'h0000, status_byte);
        cpu_comm_ok = 1'h1;
        pulse(self_test_pass);
        win(2);
        cmp("link ok", 16'h0001, status_byte[ST_LINK_OK]);
        cpu_comm_ok = 1'h0;
        win(2);
        cmp("link ok held", 16'h0001, status_byte[ST_LINK_OK]);
        pulse(link_ok_clear);
        win(2);
        cmp("link ok", 16'h0000, status_byte[ST_LINK_OK]);
        cpu_comm_ok = 1'h1;
        win(2);
        cmp("link ok", 16'h0001, status_byte[ST_LINK_OK]);
        hits = '{default: 0};
        foreach (cases[i]) run(cases[i]);
        fail = 1'h1;
        run(cases[13]);
        fail = 1'h0;
        win(90);
        cmp("done windows", 16'd27, hits[1]);
        cmp("error windows", 16'd45, hits[2]);
        hits = '{default: 0};
        pulse(ext_read_ok);
        pulse(ext_read_ok);
        pulse(ext_write_ok);
        pulse(ext_write_ok);
        pulse(quick_resp_sent);
        pulse(quick_resp_sent);
        win(16);
        cmp("read windows", 16'd3, hits[3]);
        cmp("write windows", 16'd3, hits[4]);
        cmp("quick windows", 16'd6, hits[5]);
        comm_active = 1'h1;
        hits = '{default: 0};
        pulse(quick_resp_sent);
        win(8);
        cmp("quick held", 16'd0, hits[5]);
        comm_active = 1'h0;
        win(8);
        cmp("quick after", 16'd3, hits[5]);
        diag(1'h1, 5'h00, 16'hA5A5);
        diag(1'h1, 5'h13, 16'h1234);
        diag(1'h1, 5'h14, 16'hFFFF);
        diag(1'h0, 5'h00, 16'hA5A5);
        diag(1'h0, 5'h13, 16'h1234);
        diag(1'h0, 5'h14, 16'h0000);
        pulse(diag_clear);
        diag(1'h0, 5'h13, 16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire
